// ### shared/cspt_map.svh
// Address map, field positions, reset values and counts of the serial port
`ifndef CSPT_MAP_SVH
`define CSPT_MAP_SVH

`define CSPT_ADDR_MODE 16'hff80
`define CSPT_ADDR_CLKSEL 16'hff81
`define CSPT_ADDR_TXBUF 16'hff82
`define CSPT_ADDR_SHIFT 16'hff83

`define CSPT_MODE_RESET 8'h00
`define CSPT_CLKSEL_RESET 8'h00
`define CSPT_SHIFT_RESET 8'h00
`define CSPT_TXBUF_RESET 8'h00
`define CSPT_MODE_WMASK 8'hd0
`define CSPT_CLKSEL_WMASK 8'h1f

`define CSPT_MODE_EN 7
`define CSPT_MODE_TRMD 6
`define CSPT_MODE_DIR 4
`define CSPT_MODE_BUSY 0

`define CSPT_CS_CKP 4
`define CSPT_CS_DAP 3
`define CSPT_CS_CKS_HI 2
`define CSPT_CS_CKS_LO 0
`define CSPT_CKS_SLAVE 3'h7

`define CSPT_BITS_PER_XFER 4'h8
`define CSPT_LAST_BIT 4'h7
`define CSPT_HALF_EXP_BASE 4'h1
`define CSPT_DIV_W 8
`define CSPT_FIFO_DEPTH 16
`define CSPT_DATA_W 8

`endif

// ### shared/cspt_pkg.sv
// Types shared by the serial port modules
package cspt_pkg;
    typedef logic [7:0] cspt_byte_t;
    typedef enum logic {CSPT_ST_IDLE, CSPT_ST_RUN} cspt_state_t;
endpackage

// ### shared/cspt_stream_if.sv
// Valid/ready word stream between the port and its FIFO
`timescale 1ns/1ps
interface cspt_stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface

// ### rtl/cspt_fifo.sv
// Transmit word FIFO with valid/ready on both sides
`timescale 1ns/1ps
module cspt_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic flush,
    cspt_stream_if.sink wr,
    cspt_stream_if.source rd
);
    localparam int AW = $clog2(DEPTH);
    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1) begin : g_bad
            $error("cspt_fifo: depth must be a power of two of at least 2");
        end
    endgenerate

    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wptr_ff;
    logic [AW:0] rptr_ff;
    logic full;
    logic empty;
    logic push;
    logic pop;

    assign empty = (wptr_ff == rptr_ff);
    assign full = (wptr_ff[AW] != rptr_ff[AW]) && (wptr_ff[AW-1:0] == rptr_ff[AW-1:0]);
    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data = mem[rptr_ff[AW-1:0]];
    assign push = wr.valid && !full;
    assign pop = rd.ready && !empty;

    always_ff @(posedge sys_clk) begin
        if (ce && push) begin
            mem[wptr_ff[AW-1:0]] <= wr.data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wptr_ff <= '0;
            rptr_ff <= '0;
        end else if (ce) begin
            if (flush) begin
                wptr_ff <= '0;
                rptr_ff <= '0;
            end else begin
                if (push) begin
                    wptr_ff <= wptr_ff + 1'b1;
                end
                if (pop) begin
                    rptr_ff <= rptr_ff + 1'b1;
                end
            end
        end
    end
endmodule

// ### rtl/cspt_clkgen.sv
// Serial clock divider for master mode and edge finder for slave mode
`timescale 1ns/1ps
`include "cspt_map.svh"
module cspt_clkgen
    import cspt_pkg::*;
#(
    parameter int DIV_W = `CSPT_DIV_W
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic run,
    input wire logic master,
    input wire logic [2:0] cks,
    input wire logic ckp,
    input wire logic sck_in,
    output logic sck_out,
    output logic lead,
    output logic trail
);
    generate
        if (DIV_W < 8) begin : g_bad
            $error("cspt_clkgen: divider too narrow for the slowest clock");
        end
    endgenerate

    logic [DIV_W-1:0] cnt_ff;
    logic sck_ff;
    logic sck_in_ff;
    logic idle_lvl;
    logic tick;
    logic [DIV_W-1:0] half_last;

    assign idle_lvl = !ckp;
    // Half period is 2^(code+1) cycles, full period 2^(code+2)
    assign half_last = DIV_W'((1 << (cks + `CSPT_HALF_EXP_BASE)) - 1);
    assign tick = run && master && (cnt_ff == half_last);
    assign sck_out = sck_ff;
    assign lead = master ? (tick && sck_ff == idle_lvl)
                         : (run && sck_in_ff == idle_lvl && sck_in != idle_lvl);
    assign trail = master ? (tick && sck_ff != idle_lvl)
                          : (run && sck_in_ff != idle_lvl && sck_in == idle_lvl);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt_ff <= '0;
            sck_ff <= 1'b1;
        end else if (ce) begin
            if (!run || !master) begin
                cnt_ff <= '0;
                sck_ff <= idle_lvl;
            end else if (tick) begin
                cnt_ff <= '0;
                sck_ff <= !sck_ff;
            end else begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sck_in_ff <= 1'b1;
        end else if (ce) begin
            sck_in_ff <= sck_in;
        end
    end

    a_half_period: assert property (@(posedge sys_clk) disable iff (!rst_n || !ce)
        tick |=> !tick)
        else $error("serial clock toggled in two adjacent cycles");
endmodule

// ### rtl/cspt_top.sv
// Three-wire clocked serial port with its registers
`timescale 1ns/1ps
`include "cspt_map.svh"
module cspt_top
    import cspt_pkg::*;
#(
    parameter int FIFO_DEPTH = `CSPT_FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [15:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    output logic tx_ready,
    output logic transfer_done_irq_flag,
    input wire logic serial_clock_pin_i,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe,
    output logic serial_data_out_pin,
    input wire logic serial_data_in_pin
);
    generate
        if (FIFO_DEPTH < 2) begin : g_bad
            $error("cspt_top: FIFO depth below 2 cannot queue writes");
        end
    endgenerate

    cspt_byte_t mode_ff;
    cspt_byte_t clksel_ff;
    cspt_byte_t txbuf_ff;
    cspt_byte_t sh_ff;
    cspt_byte_t rdata_ff;
    cspt_state_t state_ff;
    logic [3:0] bit_cnt_ff;
    logic so_ff;
    logic done_ff;
    logic nxt_so;

    logic port_en;
    logic trmd;
    logic dir;
    logic ckp;
    logic dap;
    logic [2:0] cks;
    logic master;
    logic shifting;
    logic busy;
    logic lead;
    logic trail;
    logic sample_edge;
    logic drive_edge;
    logic tx_start;
    logic rx_start;
    logic start;
    logic finish;
    logic sel_mode;
    logic sel_clksel;
    logic sel_txbuf;
    logic sel_shift;
    cspt_byte_t mode_rd;

    cspt_stream_if #(.W(`CSPT_DATA_W)) fifo_in ();
    cspt_stream_if #(.W(`CSPT_DATA_W)) fifo_out ();

    function automatic logic first_bit(input cspt_byte_t d, input logic lsb_first);
        first_bit = lsb_first ? d[0] : d[7];
    endfunction

    function automatic cspt_byte_t shift_in(input cspt_byte_t d, input logic b,
                                            input logic lsb_first);
        shift_in = lsb_first ? {b, d[7:1]} : {d[6:0], b};
    endfunction

    assign port_en = mode_ff[`CSPT_MODE_EN];
    assign trmd = mode_ff[`CSPT_MODE_TRMD];
    assign dir = mode_ff[`CSPT_MODE_DIR];
    assign ckp = clksel_ff[`CSPT_CS_CKP];
    assign dap = clksel_ff[`CSPT_CS_DAP];
    assign cks = clksel_ff[`CSPT_CS_CKS_HI:`CSPT_CS_CKS_LO];
    assign master = (cks != `CSPT_CKS_SLAVE);
    assign shifting = (state_ff == CSPT_ST_RUN);
    assign busy = shifting || fifo_out.valid;

    assign sel_mode = (bus_addr == `CSPT_ADDR_MODE);
    assign sel_clksel = (bus_addr == `CSPT_ADDR_CLKSEL);
    assign sel_txbuf = (bus_addr == `CSPT_ADDR_TXBUF);
    assign sel_shift = (bus_addr == `CSPT_ADDR_SHIFT);

    // Timing type: leading edge leaves idle, trailing edge returns to it
    assign sample_edge = dap ? lead : trail;
    assign drive_edge = dap ? trail : lead;

    assign fifo_in.valid = bus_wr && sel_txbuf && port_en;
    assign fifo_in.data = bus_wdata;
    assign tx_ready = fifo_in.ready;
    assign fifo_out.ready = port_en && trmd && !shifting;
    assign tx_start = fifo_out.valid && fifo_out.ready;
    assign rx_start = bus_rd && sel_shift && port_en && !trmd && !shifting;
    assign start = tx_start || rx_start;
    assign finish = shifting && (dap ? (trail && bit_cnt_ff == `CSPT_BITS_PER_XFER)
                                     : (trail && bit_cnt_ff == `CSPT_LAST_BIT));

    cspt_fifo #(.W(`CSPT_DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ce(ce),
        .flush(!port_en),
        .wr(fifo_in),
        .rd(fifo_out)
    );

    cspt_clkgen u_clkgen (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ce(ce),
        .run(shifting),
        .master(master),
        .cks(cks),
        .ckp(ckp),
        .sck_in(serial_clock_pin_i),
        .sck_out(serial_clock_pin_o),
        .lead(lead),
        .trail(trail)
    );

    // Clock pin is driven only by an enabled master
    assign serial_clock_pin_oe = port_en && master;
    assign serial_data_out_pin = so_ff;
    assign transfer_done_irq_flag = done_ff;
    assign bus_rdata = rdata_ff;

    // Mode register read view, unused bits as zero
    always_comb begin
        mode_rd = '0;
        mode_rd[`CSPT_MODE_EN] = port_en;
        mode_rd[`CSPT_MODE_TRMD] = trmd;
        mode_rd[`CSPT_MODE_DIR] = dir;
        mode_rd[`CSPT_MODE_BUSY] = busy;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mode_ff <= `CSPT_MODE_RESET;
        end else if (ce && bus_wr && sel_mode) begin
            mode_ff <= bus_wdata & `CSPT_MODE_WMASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            clksel_ff <= `CSPT_CLKSEL_RESET;
        end else if (ce && bus_wr && sel_clksel) begin
            clksel_ff <= bus_wdata & `CSPT_CLKSEL_WMASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            txbuf_ff <= `CSPT_TXBUF_RESET;
        end else if (ce && bus_wr && sel_txbuf) begin
            txbuf_ff <= bus_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdata_ff <= '0;
        end else if (ce && bus_rd) begin
            if (sel_mode) begin
                rdata_ff <= mode_rd;
            end else if (sel_clksel) begin
                rdata_ff <= clksel_ff;
            end else if (sel_txbuf) begin
                rdata_ff <= txbuf_ff;
            end else if (sel_shift) begin
                rdata_ff <= sh_ff;
            end else begin
                rdata_ff <= '0;
            end
        end
    end

    // Transfer sequencer
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_ff <= CSPT_ST_IDLE;
        end else if (ce) begin
            if (!port_en) begin
                state_ff <= CSPT_ST_IDLE;
            end else begin
                case (state_ff)
                    CSPT_ST_IDLE: begin
                        if (start) begin
                            state_ff <= CSPT_ST_RUN;
                        end
                    end
                    CSPT_ST_RUN: begin
                        if (finish) begin
                            state_ff <= CSPT_ST_IDLE;
                        end
                    end
                    default: begin
                        state_ff <= CSPT_ST_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bit_cnt_ff <= '0;
        end else if (ce) begin
            if (!port_en || start) begin
                bit_cnt_ff <= '0;
            end else if (shifting && sample_edge) begin
                bit_cnt_ff <= bit_cnt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sh_ff <= `CSPT_SHIFT_RESET;
        end else if (ce) begin
            if (!port_en) begin
                sh_ff <= `CSPT_SHIFT_RESET;
            end else if (tx_start) begin
                sh_ff <= fifo_out.data;
            end else if (shifting && sample_edge) begin
                sh_ff <= shift_in(sh_ff, serial_data_in_pin, dir);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            done_ff <= 1'b0;
        end else if (ce) begin
            done_ff <= port_en && finish;
        end
    end

    // Output latch
    always_comb begin
        nxt_so = so_ff;
        if (!trmd) begin
            nxt_so = 1'b0;
        end else if (!port_en) begin
            nxt_so = dap ? first_bit(txbuf_ff, dir) : 1'b0;
        end else if (tx_start && dap) begin
            nxt_so = first_bit(fifo_out.data, dir);
        end else if (shifting && drive_edge && !dap) begin
            nxt_so = first_bit(sh_ff, dir);
        end else if (shifting && drive_edge && dap
                     && bit_cnt_ff != `CSPT_BITS_PER_XFER) begin
            nxt_so = first_bit(sh_ff, dir);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            so_ff <= 1'b0;
        end else if (ce) begin
            so_ff <= nxt_so;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n || !ce);

    a_disable_clears: assert property (!port_en |=> !shifting && sh_ff == 8'h00)
        else $error("disabled port kept busy or shift data");
    a_reset_mode: assert property (@(posedge sys_clk) disable iff (1'b0)
        !rst_n |=> mode_ff == 8'h00)
        else $error("mode register not cleared by reset");
    a_mode_readback: assert property (bus_rd && sel_mode |=>
        rdata_ff[5] == 1'b0 && rdata_ff[3:1] == 3'h0 && rdata_ff[0] == $past(busy))
        else $error("mode read shows wrong reserved or busy bits");
    a_eight_bits: assert property (done_ff |-> $past(bit_cnt_ff) ==
        ($past(dap) ? 4'h8 : 4'h7))
        else $error("transfer ended after wrong bit count");
    a_tx_start: assert property (tx_start |=> shifting ##0 mode_rd[0])
        else $error("buffer write in transmit mode did not start transfer");
    a_rx_start: assert property (rx_start |=> shifting)
        else $error("shift register read in receive mode did not start");
    a_done_idle: assert property ($fell(shifting) && port_en |-> done_ff)
        else $error("transfer ended without done flag");
    a_rx_low: assert property (!trmd |=> !serial_data_out_pin)
        else $error("data out not low in receive-only mode");
    a_last_hold: assert property (port_en && trmd && !shifting && !start &&
        $past(port_en) && $past(!shifting) |=> $stable(so_ff))
        else $error("data out changed while idle");
    a_phase1_first: assert property (tx_start && dap |=>
        so_ff == first_bit($past(fifo_out.data), dir))
        else $error("first bit not on data out at start strobe");
    a_phase0_wait: assert property (tx_start && !dap |=> $stable(serial_data_out_pin))
        else $error("phase 0 data out changed before the first clock edge");
    a_done_pulse: assert property (done_ff |=> !done_ff)
        else $error("done flag stood for more than one cycle");
    a_rx_busy: assert property (rx_start |=> mode_rd[`CSPT_MODE_BUSY])
        else $error("receive start did not show busy");
    a_clk_idle: assert property (!shifting |=> serial_clock_pin_o == !$past(ckp))
        else $error("serial clock not at idle level between transfers");

    c_tx_done: cover property (port_en && trmd && !dap && done_ff);
    c_rx_done: cover property (port_en && !trmd && done_ff);
    c_phase1_done: cover property (port_en && trmd && dap && done_ff);
    c_slave_done: cover property (port_en && !master && done_ff);
    c_fifo_chain: cover property (done_ff && tx_start);
endmodule

// ### tb/cspt_peer.sv
// Behavioural model of the external peripheral on the serial lines
`timescale 1ns/1ps
module cspt_peer (
    input wire logic sys_clk,
    input wire logic clr,
    input wire logic sck_line,
    input wire logic sdo,
    input wire logic ckp,
    input wire logic dap,
    input wire logic lsb_first,
    input wire logic [7:0] tx_byte,
    output logic sdi,
    output logic [7:0] rx_byte
);
    logic sck_prev_ff;
    logic [2:0] cnt_ff;
    logic lead;
    logic trail;
    logic smp;
    // Edges seen against the idle level of the clock
    assign lead = (sck_prev_ff == ~ckp) && (sck_line != ~ckp);
    assign trail = (sck_prev_ff != ~ckp) && (sck_line == ~ckp);
    assign smp = dap ? lead : trail;
    // Next bit stands on the line until the device has sampled it
    assign sdi = lsb_first ? tx_byte[cnt_ff] : tx_byte[3'h7 - cnt_ff];
    always_ff @(posedge sys_clk) begin
        sck_prev_ff <= sck_line;
        if (clr) begin
            cnt_ff <= 3'h0;
            rx_byte <= 8'h00;
        end else if (smp) begin
            cnt_ff <= cnt_ff + 3'h1;
            rx_byte <= lsb_first ? {sdo, rx_byte[7:1]} : {rx_byte[6:0], sdo};
        end
    end
endmodule

// ### tb/tb_top.sv
// Self-checking testbench of the serial port
`timescale 1ns/1ps
`include "cspt_map.svh"
module tb_top
    import cspt_pkg::*;
;
    logic sys_clk;
    logic rst_n;
    logic [15:0] bus_addr;
    logic bus_wr;
    logic bus_rd;
    logic [7:0] bus_wdata;
    logic [7:0] bus_rdata;
    logic tx_ready;
    logic transfer_done_irq_flag;
    logic sck_o;
    logic sck_oe;
    logic sdo;
    logic sdi;
    logic ext_sck;
    logic sck_line;
    logic peer_clr;
    logic cfg_ckp;
    logic cfg_dap;
    logic cfg_lsb;
    logic [7:0] peer_tx;
    logic [7:0] peer_rx;
    logic [7:0] rd_v;
    int err_count;
    int samples_checked;
    int done_cnt;
    int n;
    int start;

    assign sck_line = sck_oe ? sck_o : ext_sck;

    cspt_top u_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .ce(1'b1), .bus_addr(bus_addr),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .tx_ready(tx_ready), .transfer_done_irq_flag(transfer_done_irq_flag),
        .serial_clock_pin_i(ext_sck), .serial_clock_pin_o(sck_o),
        .serial_clock_pin_oe(sck_oe), .serial_data_out_pin(sdo), .serial_data_in_pin(sdi)
    );

    cspt_peer u_peer (
        .sys_clk(sys_clk), .clr(peer_clr), .sck_line(sck_line), .sdo(sdo), .ckp(cfg_ckp),
        .dap(cfg_dap), .lsb_first(cfg_lsb), .tx_byte(peer_tx), .sdi(sdi), .rx_byte(peer_rx)
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(negedge sys_clk) begin
        if (transfer_done_irq_flag === 1'b1) begin
            done_cnt++;
        end
    end

    task automatic end_of_test();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(posedge sys_clk);
        #1;
        bus_wr = 1'b0;
    endtask

    task automatic rd_check(input logic [15:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        #1;
        bus_addr = a;
        bus_rd = 1'b1;
        @(posedge sys_clk);
        #1;
        bus_rd = 1'b0;
        check(bus_rdata, exp);
    endtask

    task automatic wait_done(input int s);
        for (int i = 0; i < 5000 && done_cnt == s; i++) @(posedge sys_clk);
        #1;
        check(8'(done_cnt - s), 8'h01);
    endtask

    // Stops the port, then loads clock select, mode bits and enable in order
    task automatic setup(input logic [7:0] cs, input logic [7:0] md);
        cfg_ckp = cs[4];
        cfg_dap = cs[3];
        cfg_lsb = md[4];
        ext_sck = ~cs[4];
        peer_clr = 1'b1;
        bus_write(`CSPT_ADDR_MODE, 8'h00);
        // Peer held clear while the clock line moves to its new idle level
        bus_write(`CSPT_ADDR_CLKSEL, cs);
        peer_clr = 1'b0;
        bus_write(`CSPT_ADDR_MODE, md);
        bus_write(`CSPT_ADDR_MODE, md | 8'h80);
    endtask

    task automatic xfer(input logic [7:0] cs, input logic dir, input logic [7:0] d,
                        input logic [7:0] pd);
        peer_tx = pd;
        setup(cs, {3'h2, dir, 4'h0});
        start = done_cnt;
        bus_write(`CSPT_ADDR_TXBUF, d);
        check({7'h0, sck_oe}, {7'h0, cs[2:0] != 3'h7});
        n = 0;
        if (cs[2:0] == 3'h7) begin
            repeat (16) begin
                repeat (4) @(posedge sys_clk);
                #1;
                ext_sck = ~ext_sck;
            end
        end else begin
            for (int i = 0; i < 600 && sck_line == ~cs[4]; i++) begin
                @(posedge sys_clk);
                #1;
            end
            while (n < 600 && sck_line != ~cs[4]) begin
                @(posedge sys_clk);
                #1;
                n++;
            end
            check(8'(n), 8'h01 << (cs[2:0] + 1));
        end
        wait_done(start);
        check(peer_rx, d);
        rd_check(`CSPT_ADDR_SHIFT, pd);
        check({7'h0, sdo}, {7'h0, dir ? d[7] : d[0]});
        rd_check(`CSPT_ADDR_MODE, {3'h6, dir, 4'h0});
        rd_check(`CSPT_ADDR_TXBUF, d);
    endtask

    initial begin
        #600000;
        err_count++;
        $display("wrong value at %0t: run did not finish", $time);
        end_of_test();
    end

    initial begin
        rst_n = 1'b0;
        bus_addr = 16'h0000;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_wdata = 8'h00;
        ext_sck = 1'b1;
        peer_clr = 1'b1;
        cfg_ckp = 1'b0;
        cfg_dap = 1'b0;
        cfg_lsb = 1'b0;
        peer_tx = 8'h00;
        err_count = 0;
        samples_checked = 0;
        done_cnt = 0;
        repeat (8) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        peer_clr = 1'b0;
        rd_check(`CSPT_ADDR_MODE, 8'h00);
        rd_check(`CSPT_ADDR_CLKSEL, 8'h00);
        rd_check(`CSPT_ADDR_SHIFT, 8'h00);
        check({6'h0, sck_oe, sdo}, 8'h00);
        bus_write(`CSPT_ADDR_MODE, 8'h7f);
        rd_check(`CSPT_ADDR_MODE, 8'h50);
        bus_write(16'hff84, 8'hff);
        rd_check(16'hff84, 8'h00);
        for (int t = 0; t < 4; t++) begin
            xfer({3'h0, 2'(t), 3'h0}, t[0], 8'hc5 ^ 8'(t * 17), 8'h3a + 8'(t));
        end
        for (int c = 1; c < 7; c++) begin
            xfer({5'h0, 3'(c)}, c[0], 8'h81 + 8'(c), 8'h7e - 8'(c));
        end
        xfer(8'h07, 1'b0, 8'ha3, 8'h5c);
        xfer(8'h1f, 1'b1, 8'h4d, 8'hb2);
        peer_tx = 8'h69;
        setup(8'h00, 8'h00);
        start = done_cnt;
        rd_check(`CSPT_ADDR_SHIFT, 8'h00);
        repeat (10) @(posedge sys_clk);
        #1;
        check({7'h0, sdo}, 8'h00);
        wait_done(start);
        check(peer_rx, 8'h00);
        start = done_cnt;
        rd_check(`CSPT_ADDR_SHIFT, 8'h69);
        wait_done(start);
        setup(8'h06, 8'h40);
        bus_write(`CSPT_ADDR_TXBUF, 8'hff);
        repeat (100) @(posedge sys_clk);
        bus_write(`CSPT_ADDR_MODE, 8'h00);
        rd_check(`CSPT_ADDR_MODE, 8'h00);
        rd_check(`CSPT_ADDR_SHIFT, 8'h00);
        setup(8'h00, 8'h40);
        start = done_cnt;
        n = 0;
        for (int i = 0; i < 40 && tx_ready === 1'b1; i++) begin
            bus_write(`CSPT_ADDR_TXBUF, 8'(i));
            n++;
        end
        check({7'h0, tx_ready}, 8'h00);
        check({7'h0, n >= 16}, 8'h01);
        for (int i = 0; i < 3000 && done_cnt - start < n; i++) @(posedge sys_clk);
        #1;
        check(8'(done_cnt - start), 8'(n));
        check({7'h0, tx_ready}, 8'h01);
        end_of_test();
    end
endmodule
